// ---- logic/mcel_logger.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "mcel_consts.svh"
module mcel_logger #(
  parameter int NUM_BANKS = `MCEL_NUM_BANKS,
  parameter int NUM_SCRUB = 3,
  parameter int LINE_W = 10,
  parameter logic [15:0] SCRUB_PERIOD = `MCEL_SCRUB_PERIOD
) (
  // clock and resets
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cold_rst,
  // control
  input wire logic i_mc_enable,
  // error report
  input wire mcel_pkg::mcel_err_t i_err,
  // scrubbers: 0 dcache, 1 l2 tags, 2 memory
  input wire logic [NUM_SCRUB-1:0] i_scrub_idle,
  input wire logic [NUM_SCRUB-1:0] i_scrub_single_err,
  // bank log and capability
  input wire logic [2:0] i_bank_sel,
  input wire logic i_bank_clear,
  output var mcel_pkg::mcel_rec_t o_bank_rec,
  output logic [8:0] o_cap,
  // exception and load-path correction
  output logic o_machine_check_exception,
  output logic o_piggy_fix,
  // scrubber outputs
  output logic [NUM_SCRUB-1:0] o_scrub_rd,
  output logic [NUM_SCRUB-1:0] o_scrub_wb,
  output logic [NUM_SCRUB*LINE_W-1:0] o_scrub_line
);
  mcel_pkg::mcel_rec_t bank_q [NUM_BANKS];
  logic [2:0] bank_d;
  logic fatal_d;
  logic piggy_d;

  // classify and route each report
  always_comb begin
    bank_d = `MCEL_BANK_DC;
    fatal_d = 1'b1;
    piggy_d = 1'b0;
    case (i_err.src)
      mcel_pkg::MCEL_SRC_DC_FILL: begin
        fatal_d = i_err.multi_bit;
      end
      mcel_pkg::MCEL_SRC_DC_DATA: begin
        // scrubbed single-bit is recoverable; unused-byte single-bit case below
        fatal_d = i_err.multi_bit | ~i_err.by_scrubber;
        // error only in bytes the load ignores: fix like scrub
        if (!i_err.multi_bit && !i_err.by_scrubber && i_err.err_bytes != 8'h00 &&
            (i_err.err_bytes & i_err.used_bytes) == 8'h00) begin
          fatal_d = 1'b0;
          piggy_d = 1'b1;
        end
      end
      mcel_pkg::MCEL_SRC_DC_PARITY: fatal_d = 1'b1;
      mcel_pkg::MCEL_SRC_IC_FILL: begin
        bank_d = `MCEL_BANK_IC; // dcache checks, icache logs
        fatal_d = i_err.multi_bit;
      end
      mcel_pkg::MCEL_SRC_BU: begin
        bank_d = `MCEL_BANK_BU;
        fatal_d = i_err.multi_bit;
      end
      mcel_pkg::MCEL_SRC_LS: bank_d = `MCEL_BANK_LS;
      mcel_pkg::MCEL_SRC_NB: begin
        bank_d = `MCEL_BANK_NB;
        fatal_d = i_err.multi_bit;
      end
      default: bank_d = `MCEL_BANK_DC;
    endcase
  end

  // per-bank record; only cold reset or a bank clear wipes it, warm reset keeps it
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic hit;
    assign hit = i_err.valid && bank_d == 3'(b);
    always_ff @(posedge i_sys_clk) begin
      if (i_cold_rst) begin
        bank_q[b] <= '0;
      end else if (hit) begin
        if (bank_q[b].valid && bank_q[b].uncorrected) begin
          bank_q[b].overflow <= 1'b1; // keep fatal record
        end else begin
          // recoverable overwrite fatal replaces recoverable
          bank_q[b].valid <= 1'b1;
          bank_q[b].uncorrected <= fatal_d; // logged either way
          bank_q[b].overflow <= bank_q[b].valid;
          bank_q[b].syndrome <= i_err.syndrome;
          bank_q[b].addr <= i_err.addr;
        end
      end else if (i_bank_clear && i_bank_sel == 3'(b)) begin
        bank_q[b] <= '0; // new error in same cycle wins over clear
      end
    end

    // a stored fatal record never moves, only overflow rises
    a_fatal_kept: assert property (@(posedge i_sys_clk) disable iff (i_cold_rst)
      (hit && bank_q[b].valid && bank_q[b].uncorrected)
      |=> bank_q[b].overflow && $stable(bank_q[b].addr) && $stable(bank_q[b].syndrome))
      else $error("fatal record overwritten");
    a_fatal_sticky: assert property (@(posedge i_sys_clk) disable iff (i_cold_rst)
      (bank_q[b].valid && bank_q[b].uncorrected && !(i_bank_clear && i_bank_sel == 3'(b)))
      |=> bank_q[b].valid && bank_q[b].uncorrected)
      else $error("fatal record lost");
    // recoverable record may be replaced by any later error
    a_recov_replace: assert property (@(posedge i_sys_clk) disable iff (i_cold_rst)
      (hit && !fatal_d && !(bank_q[b].valid && bank_q[b].uncorrected))
      |=> bank_q[b].valid && !bank_q[b].uncorrected && bank_q[b].syndrome == $past(i_err.syndrome))
      else $error("recoverable error not logged");
    a_fatal_replace: assert property (@(posedge i_sys_clk) disable iff (i_cold_rst)
      (hit && fatal_d && !(bank_q[b].valid && bank_q[b].uncorrected))
      |=> bank_q[b].uncorrected && bank_q[b].addr == $past(i_err.addr))
      else $error("fatal error did not replace record");
    // an error in the same cycle as a clear must not be lost
    a_err_wins_clear: assert property (@(posedge i_sys_clk) disable iff (i_cold_rst)
      (hit && i_bank_clear && i_bank_sel == 3'(b))
      |=> bank_q[b].valid)
      else $error("clear swallowed a new error");
    // warm reset alone leaves the log untouched
    a_log_warm_keep: assert property (@(posedge i_sys_clk) disable iff (i_cold_rst)
      (i_rst && !hit && !(i_bank_clear && i_bank_sel == 3'(b)))
      |=> $stable(bank_q[b]))
      else $error("warm reset disturbed the log");
  end

  // read port: one cycle behind the select
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_bank_rec <= '0;
    end else begin
      o_bank_rec <= (i_bank_sel < 3'(NUM_BANKS)) ? bank_q[i_bank_sel] : '0;
    end
  end

  // capability word; zero only while warm reset is held
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_cap <= '0;
    end else begin
      o_cap <= {`MCEL_CAP_CTL_PRESENT, `MCEL_CAP_COUNT};
    end
  end

  // exception pulse, gated by software enable
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_machine_check_exception <= 1'b0;
    end else begin
      o_machine_check_exception <= i_err.valid & fatal_d & i_mc_enable;
    end
  end

  // piggyback correction pulse, never with an exception
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_piggy_fix <= 1'b0;
    end else begin
      o_piggy_fix <= i_err.valid & piggy_d;
    end
  end

  // scrubbers: wait period, check next line when idle, write back fix
  for (genvar s = 0; s < NUM_SCRUB; s++) begin : g_scrub
    mcel_pkg::mcel_scrub_st_t st_q;
    logic [15:0] tmr_q;
    logic [LINE_W-1:0] line_q;
    // per-scrubber pulse flops keep one driver per output bit
    logic rd_q;
    logic wb_q;
    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        st_q <= mcel_pkg::MCEL_SC_WAIT;
        tmr_q <= '0;
        line_q <= '0;
        rd_q <= 1'b0;
        wb_q <= 1'b0;
      end else begin
        rd_q <= 1'b0;
        wb_q <= 1'b0;
        case (st_q)
          mcel_pkg::MCEL_SC_WAIT: begin
            if (tmr_q < SCRUB_PERIOD - 16'h0001) begin
              tmr_q <= tmr_q + 16'h0001;
            end else if (i_scrub_idle[s]) begin
              tmr_q <= '0;
              rd_q <= 1'b1;
              st_q <= mcel_pkg::MCEL_SC_CHECK;
            end
          end
          mcel_pkg::MCEL_SC_CHECK: begin
            if (i_scrub_single_err[s]) begin
              st_q <= mcel_pkg::MCEL_SC_FIX;
            end else begin
              line_q <= line_q + 1'b1;
              st_q <= mcel_pkg::MCEL_SC_WAIT;
            end
          end
          mcel_pkg::MCEL_SC_FIX: begin
            if (i_scrub_idle[s]) begin
              wb_q <= 1'b1;
              line_q <= line_q + 1'b1;
              st_q <= mcel_pkg::MCEL_SC_WAIT;
            end
          end
          default: st_q <= mcel_pkg::MCEL_SC_WAIT;
        endcase
      end
    end
    assign o_scrub_line[s*LINE_W +: LINE_W] = line_q;
    assign o_scrub_rd[s] = rd_q;
    assign o_scrub_wb[s] = wb_q;

    // scrubber may only touch its array in idle cycles
    a_scrub_idle_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (o_scrub_rd[s] | o_scrub_wb[s]) |-> $past(i_scrub_idle[s]))
      else $error("scrubber acted in a busy cycle");
    a_scrub_wb_fix: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_scrub_wb[s] |-> $past(st_q) == mcel_pkg::MCEL_SC_FIX)
      else $error("write-back without detected error");
    a_scrub_wb_once: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_scrub_wb[s] |=> !o_scrub_wb[s])
      else $error("write-back repeated");
    a_scrub_rd_once: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_scrub_rd[s] |=> !o_scrub_rd[s])
      else $error("scrub read repeated");
    // line pointer steps after every write-back or clean check
    a_scrub_wb_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_scrub_wb[s] |-> line_q == $past(line_q) + 1'b1)
      else $error("line not advanced after write-back");
    a_scrub_clean_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (st_q == mcel_pkg::MCEL_SC_CHECK && !i_scrub_single_err[s])
      |=> line_q == $past(line_q) + 1'b1)
      else $error("line not advanced after clean check");
    // no read before the wake-up period has run out
    a_scrub_period: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (st_q == mcel_pkg::MCEL_SC_WAIT && tmr_q < SCRUB_PERIOD - 16'h0001)
      |=> !o_scrub_rd[s])
      else $error("scrubber woke early");
  end

  // exception rules
  a_mce_needs_en: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_machine_check_exception |-> $past(i_mc_enable) && $past(fatal_d))
    else $error("exception without enable");
  a_mce_has_err: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_machine_check_exception |-> $past(i_err.valid))
    else $error("exception without error");
  a_recov_no_mce: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_err.valid && !fatal_d) |=> !o_machine_check_exception)
    else $error("recoverable error raised exception");
  a_piggy_recov: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_piggy_fix |-> !o_machine_check_exception)
    else $error("piggyback fix raised exception");
  a_ic_fill_bank: assert property (@(posedge i_sys_clk) disable iff (i_cold_rst)
    (i_err.valid && i_err.src == mcel_pkg::MCEL_SRC_IC_FILL && !bank_q[1].uncorrected)
    |=> bank_q[1].valid && bank_q[1].addr == $past(i_err.addr))
    else $error("icache fill not logged in icache bank");
  a_dc_load_fatal: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_err.valid && i_err.src == mcel_pkg::MCEL_SRC_DC_DATA && !i_err.by_scrubber
     && (i_err.err_bytes & i_err.used_bytes) != 8'h00 && i_mc_enable)
    |=> o_machine_check_exception)
    else $error("load path ecc error not fatal");
  a_parity_fatal: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_err.valid && i_err.src == mcel_pkg::MCEL_SRC_DC_PARITY && i_mc_enable)
    |=> o_machine_check_exception)
    else $error("parity error not fatal");
  a_fill_multi_fatal: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_err.valid && i_err.multi_bit && i_mc_enable && (i_err.src == mcel_pkg::MCEL_SRC_DC_FILL
     || i_err.src == mcel_pkg::MCEL_SRC_IC_FILL))
    |=> o_machine_check_exception)
    else $error("multi-bit fill error not fatal");
  // capability and read port
  a_cap_count: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $past(!i_rst) |-> o_cap[7:0] == 8'h05)
    else $error("capability count wrong");
  a_cap_present: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $past(!i_rst) |-> o_cap[8] == 1'b1)
    else $error("capability present bit wrong");
  a_rec_unused: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_bank_sel >= 3'(NUM_BANKS)) |=> o_bank_rec == '0)
    else $error("unused bank read not zero");
endmodule
`default_nettype wire

// ---- logic/mcel_consts.svh ----
// Contract
// - corrected errors logged, no exception raised
// - later recoverable may replace recoverable record
// - fatal raises exception only when enabled
// - fatal record kept, later errors set overflow
// - logs survive warm reset
// - five sources, five separate banks
// - scrubbers for dcache, l2 tags, memory
// - scrubbers read and write back only when idle
// - scrubber writes back single-bit corrections
// - dcache load/store ECC errors are fatal
// - unused-byte dcache errors corrected like scrub
// - icache fill errors logged in icache bank
// - dcache fills: single recoverable, multi fatal
// - dcache data recoverable only scrubbed or unused-byte single-bit
// - dcache tag and tlb parity are fatal
// - icache fills: single recoverable, multi fatal
// - capability low byte reads five banks
`ifndef MCEL_CONSTS_SVH
`define MCEL_CONSTS_SVH
`define MCEL_NUM_BANKS 5
`define MCEL_BANK_DC 3'h0
`define MCEL_BANK_IC 3'h1
`define MCEL_BANK_BU 3'h2
`define MCEL_BANK_LS 3'h3
`define MCEL_BANK_NB 3'h4
`define MCEL_CAP_COUNT 8'h05
`define MCEL_CAP_CTL_PRESENT 1'h1
`define MCEL_SCRUB_PERIOD 16'h0040
`endif

// ---- logic/mcel_pkg.sv ----
package mcel_pkg;
  // error source classes at the input
  typedef enum logic [2:0] {
    MCEL_SRC_DC_FILL,
    MCEL_SRC_DC_DATA,
    MCEL_SRC_DC_PARITY,
    MCEL_SRC_IC_FILL,
    MCEL_SRC_BU,
    MCEL_SRC_LS,
    MCEL_SRC_NB
  } mcel_src_t;
  // one error report
  typedef struct packed {
    logic valid;
    mcel_src_t src;
    logic multi_bit;
    logic by_scrubber;
    logic [7:0] used_bytes;
    logic [7:0] err_bytes;
    logic [15:0] syndrome;
    logic [47:0] addr;
  } mcel_err_t;
  // one bank record
  typedef struct packed {
    logic valid;
    logic uncorrected;
    logic overflow;
    logic [15:0] syndrome;
    logic [47:0] addr;
  } mcel_rec_t;
  typedef enum logic [1:0] {
    MCEL_SC_WAIT,
    MCEL_SC_CHECK,
    MCEL_SC_FIX
  } mcel_scrub_st_t;
endpackage

// ---- tb/mcel_logger_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module mcel_logger_tb_top;
  // design inputs and outputs
  logic i_sys_clk, i_rst, i_cold_rst, i_mc_enable, i_bank_clear, check_exception_present_flag, fix;
  mcel_pkg::mcel_err_t i_err;
  logic [2:0] i_scrub_idle, i_scrub_single_err, i_bank_sel, o_scrub_rd, o_scrub_wb, seen_rd, seen_wb;
  mcel_pkg::mcel_rec_t o_bank_rec;
  logic [8:0] o_cap;
  logic o_machine_check_exception, o_piggy_fix;
  logic [29:0] o_scrub_line;
  int failures = 0;
  int num_checks = 0;
  // short scrub period keeps the run brief
  mcel_logger #(.SCRUB_PERIOD(16'h0004)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cold_rst(i_cold_rst),
    .i_mc_enable(i_mc_enable), .i_err(i_err), .i_scrub_idle(i_scrub_idle),
    .i_scrub_single_err(i_scrub_single_err), .i_bank_sel(i_bank_sel), .i_bank_clear(i_bank_clear),
    .o_bank_rec(o_bank_rec), .o_cap(o_cap), .o_machine_check_exception(o_machine_check_exception),
    .o_piggy_fix(o_piggy_fix), .o_scrub_rd(o_scrub_rd), .o_scrub_wb(o_scrub_wb), .o_scrub_line(o_scrub_line));
  // 40 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one error pulse, then record {valid,uncorrected,overflow,syndrome} and pulses {exception,fix}
  task automatic err(input mcel_pkg::mcel_src_t s, input logic m, input logic sc, input logic [7:0] u,
    input logic [7:0] e, input logic [2:0] b, input logic [15:0] y, input logic [2:0] vuo,
    input logic [15:0] ey, input logic [1:0] mf);
    @(posedge i_sys_clk);
    i_err <= '{1'b1, s, m, sc, u, e, y, {45'h0, b}};
    i_bank_sel <= b;
    @(posedge i_sys_clk);
    i_err.valid <= 1'b0;
    #1;
    check_exception_present_flag = o_machine_check_exception;
    fix = o_piggy_fix;
    @(posedge i_sys_clk);
    #1;
    chk({o_bank_rec.valid, o_bank_rec.uncorrected, o_bank_rec.overflow, o_bank_rec.syndrome, check_exception_present_flag, fix},
      {vuo, ey, mf});
    chk(o_bank_rec.addr, {45'h0, b});
  endtask
  // clearing pulse on one bank
  task automatic clr(input logic [2:0] b);
    @(posedge i_sys_clk);
    i_bank_sel <= b;
    i_bank_clear <= 1'b1;
    @(posedge i_sys_clk);
    i_bank_clear <= 1'b0;
  endtask
  task automatic t_log();
    err(mcel_pkg::MCEL_SRC_DC_FILL, 0, 0, 8'h0F, 8'h01, 0, 16'h0001, 3'h4, 16'h0001, 2'h0);
    err(mcel_pkg::MCEL_SRC_DC_FILL, 0, 0, 8'h0F, 8'h01, 0, 16'h0002, 3'h5, 16'h0002, 2'h0);
    err(mcel_pkg::MCEL_SRC_DC_FILL, 1, 0, 8'h0F, 8'h01, 0, 16'h0003, 3'h7, 16'h0003, 2'h2);
    err(mcel_pkg::MCEL_SRC_DC_FILL, 0, 0, 8'h0F, 8'h01, 0, 16'h0004, 3'h7, 16'h0003, 2'h0);
    // warm reset must leave the fatal record in place
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk({o_bank_rec.valid, o_bank_rec.uncorrected, o_bank_rec.syndrome}, {2'h3, 16'h0003});
    $display("test log done");
  endtask
  task automatic t_src();
    i_mc_enable <= 1'b0;
    err(mcel_pkg::MCEL_SRC_LS, 0, 0, 8'h0F, 8'h01, 3, 16'h0011, 3'h6, 16'h0011, 2'h0);
    i_mc_enable <= 1'b1;
    err(mcel_pkg::MCEL_SRC_BU, 1, 0, 8'h0F, 8'h01, 2, 16'h0012, 3'h6, 16'h0012, 2'h2);
    err(mcel_pkg::MCEL_SRC_IC_FILL, 0, 0, 8'h0F, 8'h01, 1, 16'h0013, 3'h4, 16'h0013, 2'h0);
    err(mcel_pkg::MCEL_SRC_NB, 1, 0, 8'h0F, 8'h01, 4, 16'h0014, 3'h6, 16'h0014, 2'h2);
    clr(0);
    err(mcel_pkg::MCEL_SRC_DC_DATA, 0, 1, 8'h0F, 8'h01, 0, 16'h0021, 3'h4, 16'h0021, 2'h0);
    clr(0);
    err(mcel_pkg::MCEL_SRC_DC_DATA, 0, 0, 8'h0F, 8'hF0, 0, 16'h0022, 3'h4, 16'h0022, 2'h1);
    clr(0);
    err(mcel_pkg::MCEL_SRC_DC_DATA, 0, 0, 8'h0F, 8'h01, 0, 16'h0023, 3'h6, 16'h0023, 2'h2);
    clr(0);
    err(mcel_pkg::MCEL_SRC_DC_PARITY, 0, 0, 8'h0F, 8'h01, 0, 16'h0024, 3'h6, 16'h0024, 2'h2);
    // error and clear in one cycle: the error wins
    @(posedge i_sys_clk);
    i_err <= '{1'b1, mcel_pkg::MCEL_SRC_DC_FILL, 1'b0, 1'b0, 8'h0F, 8'h01, 16'h0031, 48'h0};
    i_bank_clear <= 1'b1;
    @(posedge i_sys_clk);
    i_err.valid <= 1'b0;
    i_bank_clear <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk(o_bank_rec.valid, 1'b1);
    // unused bank index reads as zero
    @(posedge i_sys_clk);
    i_bank_sel <= 3'h5;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk(o_bank_rec == '0, 1'b1);
    $display("test sources done");
  endtask
  // busy arrays must stall the scrubbers, idle ones let them read and fix
  task automatic t_scrub();
    @(posedge i_sys_clk);
    i_scrub_single_err <= 3'h7;
    seen_rd = 3'h0;
    seen_wb = 3'h0;
    repeat (20) begin
      @(posedge i_sys_clk);
      #1;
      seen_rd |= o_scrub_rd;
    end
    chk(seen_rd, 3'h0);
    @(posedge i_sys_clk);
    i_scrub_idle <= 3'h7;
    repeat (40) begin
      @(posedge i_sys_clk);
      #1;
      seen_rd |= o_scrub_rd;
      seen_wb |= o_scrub_wb;
    end
    chk({seen_rd, seen_wb}, 6'h3F);
    chk(o_scrub_line[9:0] != 10'h000, 1'b1);
    chk({o_scrub_line[19:10] != 10'h000, o_scrub_line[29:20] != 10'h000}, 2'h3);
    $display("test scrub done");
  endtask
  // main sequence
  initial begin
    i_rst = 1'b1;
    i_cold_rst = 1'b1;
    i_mc_enable = 1'b1;
    i_bank_clear = 1'b0;
    i_err = '0;
    i_scrub_idle = 3'h0;
    i_scrub_single_err = 3'h0;
    i_bank_sel = 3'h0;
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    i_cold_rst <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk(o_cap, 9'h105);
    t_log();
    t_src();
    t_scrub();
    end_sim();
  end
  // watchdog well beyond the roughly 125 cycles the tests need
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
